// ===== src/lss_pkg.sv
// constants, types and helpers shared by the system state sequencer
// Functional notes
// RL1: options 2,3,4,6 give ratio 1/0.9/0.8/0.6
// RL2: option 5: ratio 0.6, skip initial-voltage phase
// RL3: option 7: ratio 0.4, burst mode off
// RL4: trim-load state first, all controls off
// RL5: charging state drives only pass device
// RL6: no-HV variants skip charging state
// RL7: switch threshold reached: pass off, supply ready
// RL8: ready..boot states: only regulated supply on
// RL9: bulk start enters warm-up, fixed short dwell
// RL10: programming phase advances only on completion
// RL11: boot charge holds low-side gate high
// RL12: boot charge buffers initial voltage onto pin
// RL13: run: generator, supply, soft start on
// RL14: fault: all off, 1 s pause, restart
// RL15: faults stop or pause, then auto restart
// RL16: accept 2 ms average current fault flag
// RL17: accept 50 ms average current fault flag
// RL18: accept overvoltage, overtemperature, peak current faults
// RL19: supply below restart re-enters charging; the code does so from supply ready only
// RL20: bulk below stop halts operation
// RL21: accept line zero-crossing detection input
// RL22: any listed fault enters fault state; before run the code acts on overtemperature only
// RL23: wake-up needs bulk start, no stop, no undervoltage
// RL24: oscillator counter times pause, then restart
// RL25: faults sampled each cycle, fault wins
package lss_pkg;

   // register byte addresses on the wishbone port
   localparam logic [3:0]  ADR_CTRL      = 4'h0;
   localparam logic [3:0]  ADR_STAT      = 4'h4;
   // control register fields
   localparam int          CTRL_OPT_LSB  = 0;
   localparam logic [2:0]  OPT_RESET     = 3'h2;
   localparam logic [2:0]  OPT_NO_INIT   = 3'h5;
   localparam logic [2:0]  OPT_NO_BURST  = 3'h7;
   // status register fields
   localparam int          STAT_ZC_BIT   = 8;
   localparam int          STAT_FLG_LSB  = 16;

   // timing
   localparam int          CLK_MHZ       = 200;
   localparam int          WAKE_US       = 5;
   localparam int          BOOT_US       = 20;
   localparam int          PAUSE_MS      = 1000;
   localparam int          WAKE_CYC      = WAKE_US * CLK_MHZ;
   localparam int          BOOT_CYC      = BOOT_US * CLK_MHZ;
   localparam int          PAUSE_CYC     = PAUSE_MS * 1000 * CLK_MHZ;
   localparam int          TMR_W         = 28;

   // ratio in hundredths
   localparam logic [6:0]  R_095 = 7'h5F;
   localparam logic [6:0]  R_100 = 7'h64;
   localparam logic [6:0]  R_090 = 7'h5A;
   localparam logic [6:0]  R_080 = 7'h50;
   localparam logic [6:0]  R_060 = 7'h3C;
   localparam logic [6:0]  R_040 = 7'h28;

   typedef enum logic [7:0] {
      ST_TRIM  = 8'h01,
      ST_CHG   = 8'h02,
      ST_READY = 8'h04,
      ST_WAKE  = 8'h08,
      ST_PROG  = 8'h10,
      ST_BOOT  = 8'h20,
      ST_RUN   = 8'h40,
      ST_FAULT = 8'h80
   } lss_state_t;

   typedef struct packed {
      logic trim_done;
      logic prog_done;
      logic line_zero_cross_seen;
      logic supply_above_switch_threshold;
      logic supply_below_restart;
      logic regulated_supply_undervoltage;
      logic bulk_below_stop;
      logic bulk_above_start;
      logic avg_current_fault_long;
      logic avg_current_fault_short;
      logic peak_current_fault;
      logic overtemp_fault;
      logic output_overvoltage_fault;
   } lss_flags_t;

   typedef struct packed {
      logic waveform_gen_enable;
      logic regulated_supply_enable;
      logic soft_start_enable;
      logic pass_device_on;
   } lss_ctl_t;

   // low-to-high burst threshold ratio per option
   function automatic logic [6:0] lss_ratio(input logic [2:0] opt);
      unique case (opt)
         3'h1:    lss_ratio = R_095;
         3'h3:    lss_ratio = R_090;
         3'h4:    lss_ratio = R_080;
         3'h5:    lss_ratio = R_060;
         3'h6:    lss_ratio = R_060;
         3'h7:    lss_ratio = R_040;
         default: lss_ratio = R_100;
      endcase
   endfunction : lss_ratio

endpackage : lss_pkg

// ===== src/lss_seq.sv
// system state sequencer with wishbone register port
//
// Decided for this implementation: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
module lss_seq #(
   parameter bit                      HV_STARTUP = 1'b1,
   parameter logic [lss_pkg::TMR_W-1:0] PAUSE_CYC =
      lss_pkg::TMR_W'(lss_pkg::PAUSE_CYC)
) (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [3:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire lss_pkg::lss_flags_t flags_i,
   output lss_pkg::lss_ctl_t       ctl_o,
   output logic                    low_side_gate_o,
   output logic                    ss_init_drive_o,
   output logic                    burst_enable_o,
   output logic      [6:0]         ratio_o
);

   localparam int FW = $bits(lss_pkg::lss_flags_t);
   localparam logic [lss_pkg::TMR_W-1:0] WAKE_END =
      lss_pkg::TMR_W'(lss_pkg::WAKE_CYC - 1);
   localparam logic [lss_pkg::TMR_W-1:0] BOOT_END =
      lss_pkg::TMR_W'(lss_pkg::BOOT_CYC - 1);
   localparam logic [lss_pkg::TMR_W-1:0] PAUSE_END = PAUSE_CYC - 1'b1;

   lss_pkg::lss_flags_t           sy1_q;
   lss_pkg::lss_flags_t           sy2_q;
   lss_pkg::lss_flags_t           sy3_q;
   lss_pkg::lss_flags_t           fl_q;
   lss_pkg::lss_flags_t           fl_d;
   lss_pkg::lss_state_t           st_q;
   lss_pkg::lss_state_t           st_d;
   lss_pkg::lss_ctl_t             ctl_d;
   logic [lss_pkg::TMR_W-1:0]     tmr_q;
   logic [2:0]                    opt_q;
   logic                          zc_q;
   logic                          ack_q;
   logic [31:0]                   dat_q;
   logic                          lo_q;
   logic                          ssi_q;
   logic                          bst_q;
   logic [6:0]                    rat_q;

   // three-stage input filter: a change counts once stages two and three agree
   logic [FW-1:0] agree;
   assign agree = ~(sy2_q ^ sy3_q);
   assign fl_d  = (sy2_q & agree) | (fl_q & ~agree);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sy1_q <= '0;
         sy2_q <= '0;
         sy3_q <= '0;
         fl_q  <= '0;
      end else begin
         sy1_q <= flags_i;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         fl_q  <= fl_d;
      end
   end

   // fault decode
   logic any_fault;
   logic otp;
   logic bulk_ok;
   // RL18 independent fault sources
   assign otp       = fl_q.overtemp_fault;
   // RL22 full fault set, including RL16 RL17 RL20 flags
   assign any_fault = otp | fl_q.bulk_below_stop | fl_q.output_overvoltage_fault
                    | fl_q.peak_current_fault | fl_q.avg_current_fault_short
                    | fl_q.avg_current_fault_long
                    | fl_q.regulated_supply_undervoltage;
   // RL23 all three bulk and supply conditions together
   assign bulk_ok   = fl_q.bulk_above_start & ~fl_q.bulk_below_stop
                    & ~fl_q.regulated_supply_undervoltage;

   // per-state dwell timers share one counter
   logic wake_done;
   logic boot_done;
   logic pause_done;
   assign wake_done  = (tmr_q >= WAKE_END);
   assign boot_done  = (tmr_q >= BOOT_END);
   assign pause_done = (tmr_q >= PAUSE_END);

   // restart target after the fault pause ends
   lss_pkg::lss_state_t restart_st;
   // RL6 no charging state without HV startup
   assign restart_st = HV_STARTUP ? lss_pkg::ST_CHG : lss_pkg::ST_READY;

   // next state; in charging through run, fault entry is checked before any other move
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         lss_pkg::ST_TRIM: begin
            // RL4 trim load comes first
            if (fl_q.trim_done) begin
               if (HV_STARTUP)
                  st_d = lss_pkg::ST_CHG;
               else if (fl_q.supply_above_switch_threshold)
                  st_d = lss_pkg::ST_READY;
            end
         end
         lss_pkg::ST_CHG: begin
            // RL25 fault wins
            if (otp)
               st_d = lss_pkg::ST_FAULT;
            // RL7 threshold reached, pass device off
            else if (fl_q.supply_above_switch_threshold && !fl_q.supply_below_restart)
               st_d = lss_pkg::ST_READY;
         end
         lss_pkg::ST_READY: begin
            if (otp)
               st_d = lss_pkg::ST_FAULT;
            // RL19 supply sag recharges
            else if (HV_STARTUP && fl_q.supply_below_restart)
               st_d = lss_pkg::ST_CHG;
            // RL9 bulk start enters warm-up
            else if (bulk_ok)
               st_d = lss_pkg::ST_WAKE;
         end
         lss_pkg::ST_WAKE: begin
            if (otp)
               st_d = lss_pkg::ST_FAULT;
            // RL9 fixed dwell before advancing
            else if (wake_done && bulk_ok)
               st_d = lss_pkg::ST_PROG;
         end
         lss_pkg::ST_PROG: begin
            if (otp)
               st_d = lss_pkg::ST_FAULT;
            // RL10 wait for programming done
            else if (fl_q.prog_done)
               st_d = lss_pkg::ST_BOOT;
         end
         lss_pkg::ST_BOOT: begin
            if (otp)
               st_d = lss_pkg::ST_FAULT;
            else if (boot_done)
               st_d = lss_pkg::ST_RUN;
         end
         lss_pkg::ST_RUN: begin
            // RL15 fault pauses operation
            if (any_fault)
               st_d = lss_pkg::ST_FAULT;
         end
         lss_pkg::ST_FAULT: begin
            // RL24 pause timed, then restart
            if (pause_done)
               st_d = restart_st;
         end
         default: st_d = lss_pkg::ST_TRIM;
      endcase
   end

   // control outputs decoded from the next state so they align with st_q
   always_comb begin
      ctl_d = '0;
      unique case (st_d)
         // RL5 only pass device
         lss_pkg::ST_CHG:   ctl_d.pass_device_on = 1'b1;
         // RL8 only regulated supply
         lss_pkg::ST_READY,
         lss_pkg::ST_WAKE,
         lss_pkg::ST_PROG,
         lss_pkg::ST_BOOT:  ctl_d.regulated_supply_enable = 1'b1;
         // RL13 run enables
         lss_pkg::ST_RUN: begin
            ctl_d.waveform_gen_enable     = 1'b1;
            ctl_d.regulated_supply_enable = 1'b1;
            ctl_d.soft_start_enable       = 1'b1;
         end
         // RL4 RL14 trim and fault keep all off
         default:           ctl_d = '0;
      endcase
   end

   // state and dwell counter; counter restarts on every state change
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q  <= lss_pkg::ST_TRIM;
         tmr_q <= '0;
      end else begin
         st_q  <= st_d;
         tmr_q <= (st_d != st_q) ? '0 : tmr_q + 1'b1;
      end
   end

   // option-dependent outputs
   logic lo_d;
   logic ssi_d;
   // RL11 low-side gate during boot charge
   assign lo_d  = (st_d == lss_pkg::ST_BOOT);
   // RL12 RL2 initial voltage buffered unless option skips it
   assign ssi_d = lo_d && (opt_q != lss_pkg::OPT_NO_INIT);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_o <= '0;
         lo_q  <= 1'b0;
         ssi_q <= 1'b0;
         bst_q <= 1'b1;
         rat_q <= lss_pkg::R_100;
      end else begin
         ctl_o <= ctl_d;
         lo_q  <= lo_d;
         ssi_q <= ssi_d;
         // RL3 option 7 turns burst off
         bst_q <= (opt_q != lss_pkg::OPT_NO_BURST);
         // RL1 ratio decode
         rat_q <= lss_pkg::lss_ratio(opt_q);
      end
   end

   assign low_side_gate_o = lo_q;
   assign ss_init_drive_o = ssi_q;
   assign burst_enable_o  = bst_q;
   assign ratio_o         = rat_q;

   // wishbone decode: single-cycle answer, unmapped reads give zero
   logic req;
   logic wr_ctrl;
   logic clr_zc;
   logic [31:0] rd_d;
   assign req     = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr_ctrl = req & wb_we_i & (wb_adr_i == lss_pkg::ADR_CTRL) & wb_sel_i[0];
   assign clr_zc  = req & wb_we_i & (wb_adr_i == lss_pkg::ADR_STAT) & wb_sel_i[1]
                  & wb_dat_i[lss_pkg::STAT_ZC_BIT];
   assign rd_d    = (wb_adr_i == lss_pkg::ADR_CTRL) ? {29'h0, opt_q} :
                    (wb_adr_i == lss_pkg::ADR_STAT) ?
                    {3'h0, fl_q, 7'h0, zc_q, st_q} : 32'h0;

   // registers; a zero crossing in the clear cycle still sets the bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         opt_q <= lss_pkg::OPT_RESET;
         zc_q  <= 1'b0;
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end else begin
         ack_q <= req;
         if (req && !wb_we_i)
            dat_q <= rd_d;
         if (wr_ctrl)
            opt_q <= wb_dat_i[lss_pkg::CTRL_OPT_LSB +: 3];
         // RL21 zero crossing captured sticky
         zc_q  <= fl_q.line_zero_cross_seen | (zc_q & ~clr_zc);
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // checks on the sequencer
   fault_outs_a: assert property ( // RL14
      @(posedge clk_i) disable iff (rst_i)
      st_q == lss_pkg::ST_FAULT |-> ctl_o == '0)
      else $error("controls active in fault state");

   trim_outs_a: assert property ( // RL4
      @(posedge clk_i) disable iff (rst_i)
      st_q == lss_pkg::ST_TRIM |-> ctl_o == '0)
      else $error("controls active during trim load");

   charge_outs_a: assert property ( // RL5
      @(posedge clk_i) disable iff (rst_i)
      st_q == lss_pkg::ST_CHG |-> ctl_o == 4'h1)
      else $error("charging state drives wrong controls");

   ready_outs_a: assert property ( // RL8
      @(posedge clk_i) disable iff (rst_i)
      st_q inside {lss_pkg::ST_READY, lss_pkg::ST_WAKE, lss_pkg::ST_PROG, lss_pkg::ST_BOOT}
      |-> ctl_o == 4'h4)
      else $error("pre-run state drives wrong controls");

   run_outs_a: assert property ( // RL13
      @(posedge clk_i) disable iff (rst_i)
      st_q == lss_pkg::ST_RUN |-> ctl_o == 4'hE)
      else $error("run state drives wrong controls");

   fault_entry_a: assert property ( // RL22
      @(posedge clk_i) disable iff (rst_i)
      (st_q == lss_pkg::ST_RUN && any_fault) |=> st_q == lss_pkg::ST_FAULT)
      else $error("fault did not stop the run");

   wake_gate_a: assert property ( // RL23
      @(posedge clk_i) disable iff (rst_i)
      (st_q == lss_pkg::ST_WAKE && $past(st_q) == lss_pkg::ST_READY) |-> $past(bulk_ok))
      else $error("wake-up entered without bulk conditions");

   boot_gate_a: assert property ( // RL11
      @(posedge clk_i) disable iff (rst_i)
      st_q == lss_pkg::ST_BOOT |-> low_side_gate_o && ctl_o.waveform_gen_enable == 1'b0)
      else $error("low-side gate not held in boot charge");

   init_skip_a: assert property ( // RL2
      @(posedge clk_i) disable iff (rst_i)
      ($past(opt_q) == lss_pkg::OPT_NO_INIT) |-> !ss_init_drive_o)
      else $error("initial voltage driven with option 5");

   burst_off_a: assert property ( // RL3
      @(posedge clk_i) disable iff (rst_i)
      opt_q == lss_pkg::OPT_NO_BURST |=> !burst_enable_o && ratio_o == lss_pkg::R_040)
      else $error("burst not disabled by option 7");

   pause_hold_a: assert property ( // RL14
      @(posedge clk_i) disable iff (rst_i)
      $rose(st_q == lss_pkg::ST_FAULT) |-> (st_q == lss_pkg::ST_FAULT)[*8])
      else $error("fault pause ended early");

   ack_pulse_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   restart_path_a: assert property ( // RL24
      @(posedge clk_i) disable iff (rst_i)
      $fell(st_q == lss_pkg::ST_FAULT) |-> st_q == (HV_STARTUP ? lss_pkg::ST_CHG : lss_pkg::ST_READY))
      else $error("pause ended into the wrong state");

   early_otp_a: assert property ( // RL25
      @(posedge clk_i) disable iff (rst_i)
      (st_q inside {lss_pkg::ST_CHG, lss_pkg::ST_READY, lss_pkg::ST_WAKE, lss_pkg::ST_PROG, lss_pkg::ST_BOOT}
       && fl_q.overtemp_fault) |=> st_q == lss_pkg::ST_FAULT)
      else $error("overtemperature ignored before run");

   supply_recharge_a: assert property ( // RL19
      @(posedge clk_i) disable iff (rst_i)
      (HV_STARTUP && st_q == lss_pkg::ST_READY && fl_q.supply_below_restart && !otp) |=> st_q == lss_pkg::ST_CHG)
      else $error("supply sag did not restart charging");

   pass_off_a: assert property ( // RL7
      @(posedge clk_i) disable iff (rst_i)
      (st_q == lss_pkg::ST_CHG && fl_q.supply_above_switch_threshold && !fl_q.supply_below_restart && !otp)
      |=> st_q == lss_pkg::ST_READY && !ctl_o.pass_device_on)
      else $error("pass device not released at switch threshold");

   zc_sticky_a: assert property ( // RL21
      @(posedge clk_i) disable iff (rst_i)
      fl_q.line_zero_cross_seen |=> zc_q)
      else $error("zero crossing not captured");

endmodule : lss_seq

// ===== tb/llc_system_state_sequencer_tb_top.sv
// self-checking bench for the system state sequencer
`timescale 1ns/100ps
module llc_system_state_sequencer_tb_top;
   localparam int PAUSE = 64;
   logic                clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0]          adr = 4'h0, sel = 4'h0;
   logic [31:0]         wdat = 32'h0, rdat;
   logic                ack, lsg, ssd, burst, drain = 1'b0, prog_ok = 1'b0, zc = 1'b0;
   logic [6:0]          ratio;
   logic [6:0]          fault = 7'h20; // bulk low: park in supply ready
   lss_pkg::lss_flags_t flags;
   lss_pkg::lss_ctl_t   ctl;
   int                  n_fail = 0, checked = 0, cycles = 0;

   lss_seq #(.HV_STARTUP(1'b1), .PAUSE_CYC(lss_pkg::TMR_W'(PAUSE))) uut (.clk_i(clk), .rst_i(rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .flags_i(flags), .ctl_o(ctl), .low_side_gate_o(lsg),
      .ss_init_drive_o(ssd), .burst_enable_o(burst), .ratio_o(ratio));
   lss_partner far (.clk_i(clk), .rst_i(rst), .ctl_i(ctl), .drain_i(drain), .prog_ok_i(prog_ok),
      .zc_i(zc), .fault_i(fault), .flags_o(flags));

   always #2.5 clk = ~clk;

   // cut a hang short: the run needs about 41k cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         n_fail++;
         report_and_stop();
      end
   end

   task report_and_stop;
      $display("checks %0d fails %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   task check(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : check

   task ck_ctl(input logic [3:0] e);
      check("ctl", 32'(e), 32'(ctl));
   endtask : ck_ctl

   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge clk);
   endtask : wb

   task automatic st(output logic [7:0] s);
      logic [31:0] q;
      wb(1'b0, lss_pkg::ADR_STAT, 32'h0, q);
      s = q[7:0];
   endtask : st

   task automatic wait_ctl(input logic [3:0] v);
      int n;
      n = 0;
      while (ctl !== v && n < 20000) begin @(posedge clk); n++; end
   endtask : wait_ctl

   task automatic wait_state(input logic [7:0] v);
      logic [7:0] s;
      int n;
      n = 0;
      s = 8'h00;
      while (s !== v && n < 3000) begin st(s); n++; end
   endtask : wait_state

   function automatic logic [6:0] ratio_exp(input logic [2:0] o);
      case (o)
         3'h1: return 7'h5F;
         3'h3: return 7'h5A;
         3'h4: return 7'h50;
         3'h5, 3'h6: return 7'h3C;
         3'h7: return 7'h28;
         default: return 7'h64;
      endcase
   endfunction : ratio_exp

   task automatic t_reset;
      logic [7:0] s;
      ck_ctl(4'b0000);
      check("ratio", 32'h64, 32'(ratio));
      st(s);
      check("state", 32'h01, 32'(s));
      $display("done reset");
   endtask : t_reset

   // every option, then an unmapped read; leaves option 5 selected
   task automatic t_options;
      logic [31:0] q;
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, lss_pkg::ADR_CTRL, 32'(i), q);
         repeat (2) @(posedge clk);
         check("ratio", 32'(ratio_exp(3'(i))), 32'(ratio));
         check("burst", 32'(i != 7), 32'(burst));
      end
      wb(1'b0, 4'h8, 32'h0, q);
      check("unmapped", 32'h0, q);
      wb(1'b1, lss_pkg::ADR_CTRL, 32'h5, q);
      $display("done options");
   endtask : t_options

   // ready held by low bulk, supply collapse, then a slow programming phase
   task automatic t_start;
      logic [7:0] s;
      int n;
      wait_ctl(4'b0100);
      ck_ctl(4'b0100);
      repeat (50) @(posedge clk);
      st(s);
      check("state", 32'h04, 32'(s));
      // a current fault before run is not acted on, overtemperature is
      fault <= 7'h24;
      repeat (20) @(posedge clk);
      st(s);
      check("state", 32'h04, 32'(s));
      fault <= 7'h22;
      wait_ctl(4'b0000);
      ck_ctl(4'b0000);
      fault <= 7'h20;
      wait_ctl(4'b0100);
      ck_ctl(4'b0100);
      drain <= 1'b1;
      wait_ctl(4'b0001);
      ck_ctl(4'b0001);
      drain <= 1'b0;
      wait_ctl(4'b0100);
      fault <= 7'h00;
      wait_state(8'h10);
      repeat (200) @(posedge clk);
      st(s);
      check("state", 32'h10, 32'(s));
      ck_ctl(4'b0100);
      prog_ok <= 1'b1;
      n = 0;
      while (lsg !== 1'b1 && n < 200) begin @(posedge clk); n++; end
      check("ss drive", 32'h0, 32'(ssd));
      n = 0;
      while (lsg === 1'b1 && n < 9000) begin @(posedge clk); n++; end
      check("boot", 32'(lss_pkg::BOOT_CYC), 32'(n));
      wait_ctl(4'b1110);
      ck_ctl(4'b1110);
      $display("done startup");
   endtask : t_start

   task automatic t_zc;
      logic [31:0] q;
      zc <= 1'b1;
      repeat (6) @(posedge clk);
      zc <= 1'b0;
      repeat (6) @(posedge clk);
      wb(1'b0, lss_pkg::ADR_STAT, 32'h0, q);
      check("zc", 32'h1, 32'(q[8]));
      wb(1'b1, lss_pkg::ADR_STAT, 32'h100, q);
      wb(1'b0, lss_pkg::ADR_STAT, 32'h0, q);
      check("zc clr", 32'h0, 32'(q[8]));
      $display("done zero cross");
   endtask : t_zc

   // each fault source from run: stop, timed pause, restart through charging
   task automatic t_faults;
      logic [31:0] q;
      int n;
      wb(1'b1, lss_pkg::ADR_CTRL, 32'h2, q);
      for (int i = 0; i < 7; i++) begin
         fault <= 7'(1 << i);
         wait_ctl(4'b0000);
         ck_ctl(4'b0000);
         fault <= 7'h00;
         n = 0;
         while (ctl === 4'b0000 && n < 1000) begin @(posedge clk); n++; end
         check("pause", 32'(PAUSE), 32'(n));
         ck_ctl(4'b0001);
         if (i == 0) begin
            n = 0;
            while (lsg !== 1'b1 && n < 2000) begin @(posedge clk); n++; end
            check("ss drive", 32'h1, 32'(ssd));
         end
         wait_ctl(4'b1110);
         ck_ctl(4'b1110);
      end
      $display("done faults");
   endtask : t_faults

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_options();
      t_start();
      t_zc();
      t_faults();
      report_and_stop();
   end
endmodule : llc_system_state_sequencer_tb_top

// ===== tb/lss_partner.sv
// model of the comparators and power stage around the sequencer
`timescale 1ns/100ps
module lss_partner (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire lss_pkg::lss_ctl_t ctl_i,
   input  wire logic              drain_i,
   input  wire logic              prog_ok_i,
   input  wire logic              zc_i,
   input  wire logic [6:0]        fault_i,
   output lss_pkg::lss_flags_t    flags_o
);
   logic [5:0] vcc_q;
   logic [4:0] trim_q;

   // supply charges only through the pass device; drain models a collapse
   always_ff @(posedge clk_i) begin
      if (rst_i || drain_i) vcc_q <= 6'h00;
      else if (ctl_i.pass_device_on && vcc_q != 6'h3F) vcc_q <= vcc_q + 6'h01;
   end

   // trim load ends late enough that the first state can be read
   always_ff @(posedge clk_i) begin
      if (rst_i) trim_q <= 5'h00;
      else if (trim_q != 5'h1F) trim_q <= trim_q + 5'h01;
   end

   always_comb begin
      flags_o                               = '0;
      flags_o.trim_done                     = (trim_q == 5'h1F);
      flags_o.prog_done                     = prog_ok_i;
      flags_o.line_zero_cross_seen          = zc_i;
      flags_o.supply_above_switch_threshold = (vcc_q >= 6'h14);
      flags_o.supply_below_restart          = (vcc_q < 6'h05);
      flags_o.output_overvoltage_fault      = fault_i[0];
      flags_o.overtemp_fault                = fault_i[1];
      flags_o.peak_current_fault            = fault_i[2];
      flags_o.avg_current_fault_short       = fault_i[3];
      flags_o.avg_current_fault_long        = fault_i[4];
      flags_o.bulk_below_stop               = fault_i[5];
      flags_o.bulk_above_start              = ~fault_i[5];
      flags_o.regulated_supply_undervoltage = fault_i[6];
   end
endmodule : lss_partner
